//--- rtl/usbs_defines.svh
// Offsets, field positions, reset values and widths for the status word
// Contract
// - Writing one clears a writable flag
// - No per-transaction outcome reported here
// - Async status bit shows real schedule state
// - Async status may lag its enable
// - Periodic status shows state, may lag
// - Read-only empty detect bit, resets zero
// - Halted is zero while run/stop set
// - Halted set only after execution stops
// - All bits reset zero except halted
// - Doorbell sets advance flag on next advance
// - Bus parity or abort sets error flag
// - Bus error clears run/stop itself
// - Drain active transactions before halting
// - Frame index wrap sets rollover flag
// - Notify retire or short packet sets done
// - Transaction error sets error flag
`ifndef USBS_DEFINES_SVH
`define USBS_DEFINES_SVH

`define USBS_ADDR_W 8
`define USBS_STATUS_OFFSET 8'h24
`define USBS_STATUS_RESET 32'h0000_1000
`define USBS_ZERO_WORD 32'h0000_0000

`define USBS_BIT_ASYNC_RUN 15
`define USBS_BIT_PERIODIC_RUN 14
`define USBS_BIT_EMPTY 13
`define USBS_BIT_HALTED 12
`define USBS_BIT_ADVANCE 5
`define USBS_BIT_BUS_ERR 4
`define USBS_BIT_FRAME_WRAP 3
`define USBS_BIT_PORT_CHG 2
`define USBS_BIT_XFER_ERR 1
`define USBS_BIT_XFER_DONE 0

`define USBS_FLAG_W 6
`define USBS_FIDX_W 14
`define USBS_WRAP_BIT_1024 4'd13
`define USBS_WRAP_BIT_512 4'd12
`define USBS_WRAP_BIT_256 4'd11

`endif

//--- rtl/usbs_pkg.sv
// Types shared by the status word logic
`default_nettype none
package usbs_pkg;
   typedef enum logic [1:0]
   {
      USBS_HALTED = 2'h0,
      USBS_RUN = 2'h1,
      USBS_DRAIN = 2'h3
   } usbs_exec_type;

   typedef enum logic [1:0]
   {
      USBS_FLS_1024 = 2'h0,
      USBS_FLS_512 = 2'h1,
      USBS_FLS_256 = 2'h2,
      USBS_FLS_RSVD = 2'h3
   } usbs_fls_type;
endpackage : usbs_pkg
`default_nettype wire

//--- rtl/usbs_sched_track.sv
// Schedule status that follows its enable at schedule step boundaries
`default_nettype none
module usbs_sched_track
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic running,
   input wire logic step,
   output logic status_r
);
   // Follow enable only at a step so a half-walked schedule is never abandoned; clear at once when not running
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         status_r <= 1'b0;
      else if (!running)
         status_r <= 1'b0;
      else if (step)
         status_r <= enable;
   end
endmodule : usbs_sched_track
`default_nettype wire

//--- rtl/usbs_status_word.sv
// Controller status word: flags, schedule status and halt tracking
`include "usbs_defines.svh"
`default_nettype none
module usbs_status_word
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [`USBS_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic run_stop_ctrl,
   input wire logic async_sched_enable,
   input wire logic periodic_sched_enable,
   input wire logic async_advance_doorbell,
   input wire logic async_advanced,
   input wire logic sched_step,
   input wire logic async_empty_in,
   input wire logic pipeline_idle,
   input wire logic [1:0] frame_list_size,
   input wire logic [`USBS_FIDX_W-1:0] frame_index,
   input wire logic port_change_evt,
   input wire logic notify_on_finish_retire,
   input wire logic short_packet_evt,
   input wire logic xfer_error_evt,
   input wire logic pci_parity_err,
   input wire logic pci_master_abort,
   input wire logic pci_target_abort,
   output logic run_stop_clear,
   output logic async_sched_running,
   output logic periodic_sched_running,
   output logic async_empty_detect,
   output logic controller_halted,
   output logic [`USBS_FLAG_W-1:0] status_flags
);
   logic rst_s1_r;
   logic rst_n;
   usbs_pkg::usbs_exec_type exec_r;
   usbs_pkg::usbs_exec_type exec_nxt;
   logic [`USBS_FLAG_W-1:0] flags_r;
   logic [`USBS_FLAG_W-1:0] flags_nxt;
   logic [`USBS_FLAG_W-1:0] flag_set;
   logic [`USBS_FLAG_W-1:0] flag_clr;
   logic doorbell_pend_r;
   logic wrap_prev_r;
   logic wrap_now;
   logic bus_err;
   logic status_sel;
   logic [31:0] word;

   // Picks the frame index bit whose toggle marks a list wrap
   function automatic logic [3:0] usbs_wrap_pos(input logic [1:0] fls);
      logic [3:0] pos;
      pos = `USBS_WRAP_BIT_256;
      case (usbs_pkg::usbs_fls_type'(fls))
         usbs_pkg::USBS_FLS_1024: pos = `USBS_WRAP_BIT_1024;
         usbs_pkg::USBS_FLS_512: pos = `USBS_WRAP_BIT_512;
         default: pos = `USBS_WRAP_BIT_256;
      endcase
      return pos;
   endfunction : usbs_wrap_pos

   // Reset release through two flops
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   assign bus_err = pci_parity_err | pci_master_abort | pci_target_abort;
   assign wrap_now = frame_index[usbs_wrap_pos(frame_list_size)];
   assign status_sel = (reg_addr == `USBS_STATUS_OFFSET);

   // Execution state: run, drain the pipeline, then halt
   always_comb
   begin
      exec_nxt = exec_r;
      case (exec_r)
         usbs_pkg::USBS_HALTED:
            if (run_stop_ctrl)
               exec_nxt = usbs_pkg::USBS_RUN;
         usbs_pkg::USBS_RUN:
            if (!run_stop_ctrl)
               exec_nxt = usbs_pkg::USBS_DRAIN;
         usbs_pkg::USBS_DRAIN:
            if (run_stop_ctrl)
               exec_nxt = usbs_pkg::USBS_RUN;
            else if (pipeline_idle)
               exec_nxt = usbs_pkg::USBS_HALTED;
         default:
            exec_nxt = usbs_pkg::USBS_HALTED;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         exec_r <= usbs_pkg::USBS_HALTED;
      else
         exec_r <= exec_nxt;
   end

   // Halted follows the state and drops the cycle after run/stop is set
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         controller_halted <= 1'b1;
      else
         controller_halted <= (exec_nxt == usbs_pkg::USBS_HALTED) && !run_stop_ctrl;
   end

   // Bus error forces run/stop low; command word owns the bit
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         run_stop_clear <= 1'b0;
      else
         run_stop_clear <= bus_err;
   end

   // Doorbell waits for the next advance of the async schedule
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         doorbell_pend_r <= 1'b0;
      else if (async_advance_doorbell)
         doorbell_pend_r <= 1'b1;
      else if (async_advanced)
         doorbell_pend_r <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         wrap_prev_r <= 1'b0;
      else
         wrap_prev_r <= wrap_now;
   end

   // Event sources feeding the sticky flags
   always_comb
   begin
      flag_set = '0;
      flag_set[`USBS_BIT_XFER_DONE] = notify_on_finish_retire | short_packet_evt;
      flag_set[`USBS_BIT_XFER_ERR] = xfer_error_evt;
      flag_set[`USBS_BIT_PORT_CHG] = port_change_evt;
      flag_set[`USBS_BIT_FRAME_WRAP] = wrap_now ^ wrap_prev_r;
      flag_set[`USBS_BIT_BUS_ERR] = bus_err;
      flag_set[`USBS_BIT_ADVANCE] = doorbell_pend_r & async_advanced;
   end

   // Only ones in the low flag field clear; zeros and upper bits ignored
   assign flag_clr = (reg_wr && status_sel) ? reg_wdata[`USBS_FLAG_W-1:0] : '0;
   assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         flags_r <= '0;
      else
         flags_r <= flags_nxt;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         status_flags <= '0;
      else
         status_flags <= flags_nxt;
   end

   usbs_sched_track u_async_track
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .enable(async_sched_enable),
      .running(run_stop_ctrl),
      .step(sched_step),
      .status_r(async_sched_running)
   );

   usbs_sched_track u_periodic_track
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .enable(periodic_sched_enable),
      .running(run_stop_ctrl),
      .step(sched_step),
      .status_r(periodic_sched_running)
   );

   // Empty detect is meaningful only while the async schedule runs
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         async_empty_detect <= 1'b0;
      else
         async_empty_detect <= async_empty_in & async_sched_running;
   end

   // Readback; reserved bits read zero, no transaction outcome bits exist
   always_comb
   begin
      word = `USBS_ZERO_WORD;
      word[`USBS_BIT_ASYNC_RUN] = async_sched_running;
      word[`USBS_BIT_PERIODIC_RUN] = periodic_sched_running;
      word[`USBS_BIT_EMPTY] = async_empty_detect;
      word[`USBS_BIT_HALTED] = controller_halted & ~run_stop_ctrl;
      word[`USBS_FLAG_W-1:0] = flags_r;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= `USBS_ZERO_WORD;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
         begin
            if (status_sel)
               reg_rdata <= word;
            else
               reg_rdata <= `USBS_ZERO_WORD;
         end
      end
   end
endmodule : usbs_status_word
`default_nettype wire

//--- bench/usbs_status_word_checker.sv
// Port assertions for the status word
`default_nettype none
module usbs_status_word_checker
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic run_stop_ctrl,
   input wire logic pipeline_idle,
   input wire logic port_change_evt,
   input wire logic pci_parity_err,
   input wire logic pci_master_abort,
   input wire logic pci_target_abort,
   input wire logic run_stop_clear,
   input wire logic async_sched_running,
   input wire logic periodic_sched_running,
   input wire logic controller_halted,
   input wire logic [5:0] status_flags
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic bus_err;
   logic clr2;
   assign bus_err = pci_parity_err | pci_master_abort | pci_target_abort;
   assign clr2 = reg_wr && reg_addr == 8'h24 && reg_wdata[2];
   AST_CLEAR: assert property (clr2 && !port_change_evt |=> !status_flags[2])
      else $error("flag not cleared");
   AST_KEEP: assert property (status_flags[2] && !clr2 |=> status_flags[2])
      else $error("flag lost");
   AST_SET_WINS: assert property (port_change_evt |=> status_flags[2])
      else $error("event lost");
   AST_RUN_CLEAR: assert property (run_stop_clear == $past(bus_err))
      else $error("run stop clear wrong");
   AST_ERR_FLAG: assert property (bus_err |=> status_flags[4])
      else $error("bus error flag missing");
   AST_HALT_LOW: assert property (run_stop_ctrl |=> !controller_halted)
      else $error("halted while running");
   AST_HALT_SET: assert property ($rose(controller_halted) |->
      !$past(run_stop_ctrl) && $past(pipeline_idle)) else $error("early halt");
   AST_DRAIN: assert property (!pipeline_idle && !controller_halted |=>
      !controller_halted) else $error("halt during drain");
   AST_SCHED_OFF: assert property (!run_stop_ctrl |=>
      !async_sched_running && !periodic_sched_running) else $error("schedule on");
   COV_CLEAR: cover property (clr2 && status_flags[2]);
   COV_HALT: cover property ($rose(controller_halted));
   COV_BUS: cover property (bus_err ##1 run_stop_clear);
endmodule : usbs_status_word_checker
bind usbs_status_word usbs_status_word_checker usbs_status_word_checker_inst
(
   .mclk, .rst_b, .reg_wr, .reg_addr, .reg_wdata, .run_stop_ctrl, .pipeline_idle,
   .port_change_evt, .pci_parity_err, .pci_master_abort, .pci_target_abort, .run_stop_clear,
   .async_sched_running, .periodic_sched_running, .controller_halted, .status_flags
);
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the status word
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, run_stop_ctrl = 0;
   logic async_sched_enable = 0, periodic_sched_enable = 0, async_advance_doorbell = 0;
   logic async_advanced = 0, sched_step = 0, async_empty_in = 0, pipeline_idle = 0;
   logic [7:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0;
   logic [1:0] frame_list_size = 0;
   logic [13:0] frame_index = 0;
   logic [6:0] ev = 0;
   logic port_change_evt, notify_on_finish_retire, short_packet_evt, xfer_error_evt;
   logic pci_parity_err, pci_master_abort, pci_target_abort, reg_rvalid, run_stop_clear;
   logic async_sched_running, periodic_sched_running, async_empty_detect, controller_halted;
   logic [31:0] reg_rdata;
   logic [5:0] status_flags;
   int err_count, tests_run;
   // Event bits above, expected flags in the low six
   logic [12:0] rows [7] = '{13'h1004, 13'h0801, 13'h0401, 13'h0202, 13'h0110, 13'h0090,
      13'h0050};
   assign {port_change_evt, notify_on_finish_retire, short_packet_evt, xfer_error_evt,
      pci_parity_err, pci_master_abort, pci_target_abort} = ev;
   usbs_status_word usbs_status_word_inst
   (
      .mclk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
      .run_stop_ctrl, .async_sched_enable, .periodic_sched_enable, .async_advance_doorbell,
      .async_advanced, .sched_step, .async_empty_in, .pipeline_idle, .frame_list_size,
      .frame_index, .port_change_evt, .notify_on_finish_retire, .short_packet_evt,
      .xfer_error_evt, .pci_parity_err, .pci_master_abort, .pci_target_abort,
      .run_stop_clear, .async_sched_running, .periodic_sched_running, .async_empty_detect,
      .controller_halted, .status_flags
   );
   always #4 mclk = ~mclk;
   task chk(input string nm, input logic [32:0] s, input logic [32:0] e);
      tests_run++;
      if (s !== e)
      begin
         err_count++;
         $display("unexpected %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge mclk) reg_rd <= 1'b0;
      #1 chk("read", {reg_rvalid, reg_rdata}, {1'b1, e});
   endtask : rd
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge mclk) reg_wr <= 1'b0;
   endtask : wr
   task finish_test;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk("outs", {async_sched_running, periodic_sched_running, controller_halted}, 1);
      rd(8'h24, 32'h0000_1000);
      @(posedge mclk) {run_stop_ctrl, async_sched_enable, periodic_sched_enable} <= 3'h7;
      async_empty_in <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk("lag", {async_sched_running, periodic_sched_running, controller_halted}, 0);
      @(posedge mclk) sched_step <= 1'b1;
      @(posedge mclk) sched_step <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk("sched", {async_sched_running, periodic_sched_running, async_empty_detect}, 7);
      foreach (rows[i])
      begin
         @(posedge mclk) ev <= rows[i][12:6];
         @(posedge mclk) ev <= 7'h0;
         #1 chk("flags", {run_stop_clear, status_flags}, rows[i][6:0] & 7'h3F | {rows[i][4], 6'h0});
         rd(8'h24, 32'h0000_E000 | rows[i][5:0]);
         wr(8'h24, 32'h0000_003F);
         #1 chk("clear", status_flags, 0);
      end
      // Read-only bits and an unmapped offset must not disturb the flag
      @(posedge mclk) ev <= 7'h40;
      @(posedge mclk) ev <= 7'h0;
      wr(8'h24, 32'h0000_F000);
      wr(8'h28, 32'h0000_003F);
      rd(8'h28, 32'h0000_0000);
      rd(8'h24, 32'h0000_E004);
      @(posedge mclk) {ev, reg_wr, reg_addr, reg_wdata} <= {7'h40, 9'h124, 32'h0000_003F};
      @(posedge mclk) {ev, reg_wr} <= 8'h0;
      #1 chk("setwins", status_flags, 6'h04);
      wr(8'h24, 32'h0000_003F);
      // An advance with no doorbell rung must leave the flag alone
      @(posedge mclk) async_advanced <= 1'b1;
      @(posedge mclk) async_advanced <= 1'b0;
      #1 chk("noring", status_flags, 0);
      @(posedge mclk) async_advance_doorbell <= 1'b1;
      @(posedge mclk) {async_advance_doorbell, async_advanced} <= 2'b01;
      @(posedge mclk) async_advanced <= 1'b0;
      #1 chk("advance", status_flags, 6'h20);
      // Size code 3 is reserved and wraps like the smallest list
      for (int k = 0; k < 4; k++)
      begin
         @(posedge mclk) frame_list_size <= k[1:0];
         wr(8'h24, 32'h0000_003F);
         @(posedge mclk) frame_index <= frame_index ^ (14'h2000 >> (k > 2 ? 2 : k));
         repeat (2) @(posedge mclk);
         #1 chk("wrap", status_flags, 6'h08);
      end
      @(posedge mclk) {run_stop_ctrl, pipeline_idle} <= 2'b00;
      repeat (4) @(posedge mclk);
      #1 chk("drain", {controller_halted, async_sched_running}, 0);
      @(posedge mclk) pipeline_idle <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk("halted", controller_halted, 1);
      rd(8'h24, 32'h0000_1008);
      // Reset after the controller has halted must drop the sticky flags and keep halted
      @(posedge mclk) rst_b <= 1'b0;
      @(posedge mclk) rst_b <= 1'b1;
      #1 chk("rerst", {status_flags, controller_halted}, 7'h01);
      repeat (3) @(posedge mclk);
      rd(8'h24, 32'h0000_1000);
      finish_test();
   end
   initial
   begin
      // Run needs about 135 cycles
      repeat (2000) @(posedge mclk);
      err_count++;
      finish_test();
   end
endmodule : tb
`default_nettype wire
